// ==== dv/pmca_chk.sv ====
// port assertions of the config block
module pmca_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_write,
  input wire logic        cmd_read,
  input wire logic        cmd_ack,
  input wire logic        measure_shutdown,
  input wire logic        alert_out,
  input wire logic        alert_oe,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic [1:0]  measure_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] cfg;
  wire cfg_hit = cmd_code == 8'hd0;
  wire out_hit = cmd_read && (cmd_code == 8'h8b || cmd_code == 8'h8c || cmd_code == 8'h96);
  always @(posedge clk) cfg <= rst ? 16'h0000 : (cmd_write && cfg_hit) ? cmd_wdata : cfg;
  property p_ack; (cmd_write || cmd_read) && cfg_hit |=> cmd_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_refuse; (cmd_write || cmd_read) && !cfg_hit && !out_hit |=> !cmd_ack; endproperty
  a_refuse: assert property (p_refuse) else $error("bad ack");
  property p_cfg; cmd_read && cfg_hit |=> cmd_rdata == $past(cfg); endproperty
  a_cfg: assert property (p_cfg) else $error("config readback");
  property p_pad; out_hit |=> cmd_ack && cmd_rdata[5:0] == 6'h00; endproperty
  a_pad: assert property (p_pad) else $error("output pad");
  property p_shdn; cmd_write && cfg_hit |-> ##2 measure_shutdown == $past(cfg[4]); endproperty
  a_shdn: assert property (p_shdn) else $error("shutdown");
  property p_od; !alert_out; endproperty
  a_od: assert property (p_od) else $error("alert driven high");
  property p_sel; measure_select != 2'h3; endproperty
  a_sel: assert property (p_sel) else $error("selection");
  property p_rst; disable iff (1'b0) rst |=> !cmd_ack && !alert_oe && cmd_rdata == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  cover property (out_hit);
  cover property (alert_oe && cfg[8]);
  cover property (measure_shutdown);
endmodule

// ==== dv/pmca_host.sv ====
// bus host model issuing decoded commands
module pmca_host (
  input  wire logic        clk,
  input  wire logic        cmd_ack,
  input  wire logic [15:0] cmd_rdata,
  output logic             cmd_write,
  output logic             cmd_read,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cmd_write, cmd_read, cmd_code, cmd_wdata} = '0;
  task automatic op(input bit w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q, output bit a);
    @(negedge clk);
    {cmd_write, cmd_read, cmd_code, cmd_wdata} = {w, !w, c, d};
    @(negedge clk);
    {cmd_write, cmd_read, cmd_wdata} = {2'b00, ~d};
    a = cmd_ack;
    q = cmd_rdata;
  endtask
endmodule

// ==== dv/power_monitor_config_alert_test.sv ====
// self-checking bench of the config block
module power_monitor_config_alert_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ext = 0, wr, rr, ack, shd, aout, aoe;
  logic [9:0] ps = 10'h101, vs = 10'h0c4, cs = 10'h2a8;
  logic [15:0] wd, rd, q;
  logic [7:0] cd;
  logic [1:0] sel;
  bit a;
  int error_cnt = 0, checks = 0;
  // cfg, read code, expected output; selection 11 never written
  logic [15:0] rows [4][3] = '{'{16'h0020, 16'h0096, 16'h4040}, '{16'h0060, 16'h008b, 16'h3100},
                               '{16'h00a0, 16'h008c, 16'haa00}, '{16'h0060, 16'h0096, 16'h3100}};
  initial forever #2.5 clk = ~clk;
  initial forever #80 ext = ~ext;
  pmca_core u_dut (.clk(clk), .rst(rst), .external_timebase_pin(ext), .cmd_write(wr), .cmd_read(rr),
    .cmd_code(cd), .cmd_wdata(wd), .cmd_rdata(rd), .cmd_ack(ack), .power_sample(ps), .voltage_sample(vs),
    .current_sample(cs), .measure_shutdown(shd), .measure_select(sel), .alert_out(aout), .alert_oe(aoe));
  pmca_host u_host (.clk(clk), .cmd_ack(ack), .cmd_rdata(rd), .cmd_write(wr), .cmd_read(rr), .cmd_code(cd),
    .cmd_wdata(wd));
  task chk(input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task op(input bit w, input logic [7:0] c, input logic [15:0] d, input bit ea);
    u_host.op(w, c, d, q, a);
    chk(a, ea);
  endtask
  task finish_test;
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 0;
    op(0, 8'hd0, 0, 1);
    chk(q, 16'h0000);
    // shutdown lets the timebase switch land at once
    op(1, 8'hd0, 16'h0030, 1);
    op(0, 8'hd0, 0, 1);
    chk(q, 16'h0030);
    chk(shd, 1);
    foreach (rows[i]) begin
      op(1, 8'hd0, rows[i][0], 1);
      repeat (100) @(negedge clk);
      @(posedge ext);
      repeat (10) @(negedge clk);
      chk(aoe, 1);
      op(0, rows[i][1][7:0], 0, 1);
      chk(q, rows[i][2]);
      chk(aoe, 0);
      chk(shd, 0);
      chk(sel, rows[i][0][7:6]);
    end
    // averaging over two milliseconds; old selection still loads the first result
    op(1, 8'hd0, 16'h0021, 1);
    @(posedge aoe);
    op(0, 8'h96, 0, 1);
    chk(q, 16'h3100);
    @(posedge ext);
    repeat (10) @(negedge clk);
    chk(aoe, 0);
    @(posedge ext);
    repeat (10) @(negedge clk);
    chk(aoe, 1);
    op(0, 8'h8c, 0, 1);
    chk(q, 16'h4040);
    op(1, 8'hd0, 16'h2120, 1);
    @(negedge clk) ps = 10'h043;
    repeat (100) @(negedge clk);
    chk(aoe, 0);
    @(negedge clk) ps = 10'h044;
    repeat (100) @(negedge clk);
    chk(aoe, 1);
    // leaving threshold mode away from an interval end
    @(posedge ext);
    repeat (10) @(negedge clk);
    op(1, 8'hd0, 16'h0020, 1);
    @(negedge clk);
    chk(aoe, 0);
    op(0, 8'hd2, 0, 0);
    chk(q, 16'h0000);
    op(1, 8'h8b, 16'h1234, 0);
    // reset in mid run
    @(negedge clk) rst = 1;
    repeat (4) @(negedge clk);
    rst = 0;
    op(0, 8'hd0, 0, 1);
    chk(q, 16'h0000);
    chk(aoe, 0);
    chk(sel, 2'h0);
    finish_test;
  end
  initial begin
    #50000;
    error_cnt++;
    finish_test;
  end
endmodule
bind pmca_core pmca_chk u_chk (
  .clk             (clk),
  .rst             (rst),
  .cmd_write       (cmd_write),
  .cmd_read        (cmd_read),
  .cmd_ack         (cmd_ack),
  .measure_shutdown(measure_shutdown),
  .alert_out       (alert_out),
  .alert_oe        (alert_oe),
  .cmd_code        (cmd_code),
  .cmd_wdata       (cmd_wdata),
  .cmd_rdata       (cmd_rdata),
  .measure_select  (measure_select)
);

// ==== include/pmca_regs.vh ====
// register map, field positions and timing constants of the power monitor config block
`ifndef PMCA_REGS_VH
`define PMCA_REGS_VH
`define PMCA_CMD_CONFIG     8'hd0
`define PMCA_CMD_READ_VOUT  8'h8b
`define PMCA_CMD_READ_IOUT  8'h8c
`define PMCA_CMD_READ_POUT  8'h96
`define PMCA_CFG_RESET      16'h0000
`define PMCA_AVG_LSB        0
`define PMCA_AVG_MSB        3
`define PMCA_AVG_MAX        4'h8
`define PMCA_SHDN_BIT       4
`define PMCA_EXTERNAL_TIMEBASE_PIN_BIT     5
`define PMCA_SEL_LSB        6
`define PMCA_SEL_MSB        7
`define PMCA_ALERT_MODE_BIT 8
`define PMCA_THR_LSB        9
`define PMCA_THR_MSB        15
`define PMCA_SEL_POWER      2'h0
`define PMCA_SEL_VOLTAGE    2'h1
`define PMCA_SEL_CURRENT    2'h2
`define PMCA_CLK_MHZ        200
`define PMCA_MS_US          1000
`define PMCA_MS_CYCLES      (`PMCA_CLK_MHZ * `PMCA_MS_US)
`define PMCA_EXT_EDGES_MS   32'h0000_0001
`endif

// ==== verilog/pmca_core.v ====
// configuration word, output register and alert logic of the power monitor
`include "pmca_regs.vh"
module pmca_core (
  input  wire        clk,
  input  wire        rst,
  input  wire        external_timebase_pin,
  input  wire        cmd_write,
  input  wire        cmd_read,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_wdata,
  output reg  [15:0] cmd_rdata,
  output reg         cmd_ack,
  input  wire [9:0]  power_sample,
  input  wire [9:0]  voltage_sample,
  input  wire [9:0]  current_sample,
  output reg         measure_shutdown,
  output reg  [1:0]  measure_select,
  output wire        alert_out,
  output wire        alert_oe
);
  reg  [15:0] config_word;
  reg  [15:0] result;
  reg         alert_low;
  reg         thr_mode_q;
  reg  [3:0]  avg_exp;
  reg         use_ext;
  reg  [2:0]  ext_sync;
  reg  [31:0] tick_cnt;
  reg  [8:0]  ms_cnt;
  reg         ext_level;
  reg         next_cmd_ack;
  reg  [15:0] next_cmd_rdata;
  reg  [15:0] next_config_word;
  reg  [3:0]  next_avg_exp;
  reg         next_alert_low;
  reg  [31:0] next_tick_cnt;
  reg  [8:0]  next_ms_cnt;
  wire        ext_rise;
  wire        ms_tick;
  wire        interval_done;
  wire        load_result;
  wire [9:0]  chosen;
  wire [6:0]  threshold;
  wire        above;
  wire        thr_mode;
  wire        cfg_hit;
  wire        out_hit;
  wire        is_read_out;
  wire [3:0]  req_exp;
  wire [8:0]  last_ms;

  // three-stage sampler; edge counted once stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      ext_sync  <= 3'h0;
      ext_level <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_timebase_pin};
      if (ext_sync[1] == ext_sync[2])
        ext_level <= ext_sync[2];
    end
  end
  assign ext_rise = (ext_sync[1] == ext_sync[2]) && ext_sync[2] && !ext_level;

  // one millisecond base, from internal count or external edges
  assign ms_tick = use_ext ? (ext_rise && tick_cnt >= `PMCA_EXT_EDGES_MS - 32'h0000_0001)
                           : (tick_cnt == `PMCA_MS_CYCLES - 1);
  assign last_ms       = (9'h001 << avg_exp) - 9'h001;
  assign interval_done = ms_tick && (ms_cnt == last_ms);
  assign load_result   = interval_done && !measure_shutdown;

  // counters cleared in shutdown so a wake-up starts a full interval
  always @* begin
    next_tick_cnt = tick_cnt;
    next_ms_cnt   = ms_cnt;
    if (measure_shutdown) begin
      next_tick_cnt = 32'h0000_0000;
      next_ms_cnt   = 9'h000;
    end else begin
      if (ms_tick)
        next_tick_cnt = 32'h0000_0000;
      else if (!use_ext || ext_rise)
        next_tick_cnt = tick_cnt + 32'h0000_0001;
      if (interval_done)
        next_ms_cnt = 9'h000;
      else if (ms_tick)
        next_ms_cnt = ms_cnt + 9'h001;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
      ms_cnt   <= 9'h000;
    end else begin
      tick_cnt <= next_tick_cnt;
      ms_cnt   <= next_ms_cnt;
    end
  end

  assign cfg_hit     = (cmd_code == `PMCA_CMD_CONFIG);
  assign is_read_out = (cmd_code == `PMCA_CMD_READ_VOUT) || (cmd_code == `PMCA_CMD_READ_IOUT) ||
                       (cmd_code == `PMCA_CMD_READ_POUT);
  assign out_hit     = cmd_read && is_read_out;

  // host command port; config writes, reads answered next cycle
  always @* begin
    next_config_word = config_word;
    next_cmd_ack     = 1'b0;
    next_cmd_rdata   = cmd_rdata;
    if (cmd_write && cfg_hit) begin
      next_config_word = cmd_wdata;
      next_cmd_ack     = 1'b1;
    end
    if (cmd_read) begin
      if (cfg_hit) begin
        next_cmd_rdata = config_word;
        next_cmd_ack   = 1'b1;
      end else if (is_read_out) begin
        next_cmd_rdata = result;
        next_cmd_ack   = 1'b1;
      end else begin
        // refused codes, reserved ones too, read as zero and get no ack
        next_cmd_rdata = 16'h0000;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      config_word <= `PMCA_CFG_RESET;
      cmd_rdata   <= 16'h0000;
      cmd_ack     <= 1'b0;
    end else begin
      config_word <= next_config_word;
      cmd_rdata   <= next_cmd_rdata;
      cmd_ack     <= next_cmd_ack;
    end
  end

  // exponents above eight are clamped rather than wrapped
  assign req_exp = config_word[`PMCA_AVG_MSB:`PMCA_AVG_LSB];
  always @* begin
    next_avg_exp = req_exp;
    if (req_exp > `PMCA_AVG_MAX)
      next_avg_exp = `PMCA_AVG_MAX;
  end

  // averaging, timebase and selection follow the word only at interval end or while shut down, so a running average is never cut
  always @(posedge clk) begin
    if (rst) begin
      avg_exp          <= 4'h0;
      use_ext          <= 1'b0;
      measure_select   <= `PMCA_SEL_POWER;
      measure_shutdown <= 1'b0;
    end else begin
      measure_shutdown <= config_word[`PMCA_SHDN_BIT];
      if (interval_done || measure_shutdown) begin
        avg_exp        <= next_avg_exp;
        use_ext        <= config_word[`PMCA_EXTERNAL_TIMEBASE_PIN_BIT];
        measure_select <= config_word[`PMCA_SEL_MSB:`PMCA_SEL_LSB];
      end
    end
  end

  // pattern 11 is left to the master to avoid; treated as power here
  assign chosen = (measure_select == `PMCA_SEL_VOLTAGE) ? voltage_sample :
                  (measure_select == `PMCA_SEL_CURRENT) ? current_sample : power_sample;

  always @(posedge clk) begin
    if (rst)
      result <= 16'h0000;
    else if (load_result)
      result <= {chosen, 6'h00};
  end

  assign thr_mode  = config_word[`PMCA_ALERT_MODE_BIT];
  assign threshold = config_word[`PMCA_THR_MSB:`PMCA_THR_LSB];
  // result bits 15..8 are count bits 9..2; threshold taken as non-negative
  assign above = ($signed(result[15:8]) > $signed({1'b0, threshold}));

  // new-data flag: a load in the same cycle as a read wins, so no result goes unannounced
  always @* begin
    next_alert_low = alert_low;
    if (thr_mode)
      next_alert_low = above;
    else if (load_result)
      next_alert_low = 1'b1;
    else if (out_hit)
      next_alert_low = 1'b0;
    else if (thr_mode_q)
      next_alert_low = 1'b0;
  end

  always @(posedge clk) begin
    if (rst) begin
      alert_low  <= 1'b0;
      thr_mode_q <= 1'b0;
    end else begin
      alert_low  <= next_alert_low;
      thr_mode_q <= thr_mode;
    end
  end

  // open drain: the pin is only ever pulled low, never driven high
  assign alert_out = 1'b0;
  assign alert_oe  = alert_low;
endmodule
